// ---- include/tdc_pkg.sv ----
// tap detect package: register offsets, field positions, reset values, detector states
// assumes an 8-bit register port and per-axis samples scaled at one count per threshold step
package tdc_pkg;
  // register offsets
  localparam logic [7:0] TDC_OFF_CFG = 8'h21;
  localparam logic [7:0] TDC_OFF_SRC = 8'h22;
  localparam logic [7:0] TDC_OFF_THX = 8'h23;
  localparam logic [7:0] TDC_OFF_THY = 8'h24;
  localparam logic [7:0] TDC_OFF_THZ = 8'h25;
  // tap_config fields
  localparam int TDC_CFG_ABORT = 7;
  localparam int TDC_CFG_LATCH = 6;
  localparam int TDC_CFG_ZD = 5;
  localparam int TDC_CFG_ZS = 4;
  localparam int TDC_CFG_YD = 3;
  localparam int TDC_CFG_YS = 2;
  localparam int TDC_CFG_XD = 1;
  localparam int TDC_CFG_XS = 0;
  // tap_source fields
  localparam int TDC_SRC_EA = 7;
  localparam int TDC_SRC_AX_LO = 4;
  localparam int TDC_SRC_DBL = 3;
  localparam int TDC_SRC_POL_LO = 0;
  // reset values
  localparam logic [7:0] TDC_RST_CFG = 8'h00;
  localparam logic [7:0] TDC_RST_SRC = 8'h00;
  localparam logic [6:0] TDC_RST_THR = 7'h00;
  localparam logic [7:0] TDC_RST_CNT = 8'h00;
  localparam logic [7:0] TDC_RD_UNMAPPED = 8'h00;
  // per-axis detector states
  typedef enum logic [2:0] {
    TDC_IDLE = 3'b000,
    TDC_ABOVE = 3'b001,
    TDC_WAIT_LOW = 3'b010,
    TDC_LATENCY = 3'b011,
    TDC_WINDOW = 3'b100,
    TDC_ABOVE2 = 3'b101
  } tdc_state_t;
endpackage : tdc_pkg

// ---- sim/tb.sv ----
// testbench for the tap detect register set
// assumes the host model owns the register port and this module drives the samples
`timescale 1ns/10ps
module tb;
  logic core_clk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  logic sample_tick;
  logic signed [7:0] accel_x;
  logic signed [7:0] accel_y;
  logic signed [7:0] accel_z;
  logic tap_irq_ff;
  logic [7:0] junk;
  bit jok;
  int err_total;
  int n_compared;
  // single cases and refusals: config, axis, value, ticks above, expected source
  logic [7:0] t_cfg[7] = '{8'h41, 8'h44, 8'h50, 8'h41, 8'h41, 8'h42, 8'h41};
  int t_ax[7] = '{0, 1, 2, 2, 0, 0, 0};
  logic signed [7:0] t_val[7] = '{8'sh05, 8'shfc, 8'sh03, 8'sh05, 8'sh02, 8'sh05, 8'sh05};
  int t_len[7] = '{1, 1, 1, 1, 1, 1, 6};
  logic [7:0] t_exp[7] = '{8'h90, 8'ha2, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00};

  // 250 MHz clock
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  tdc_top uut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .sample_tick(sample_tick), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .tap_time_limit(8'h03), .tap_latency_window(8'h03), .tap_second_window(8'h06), .tap_irq_ff(tap_irq_ff)
  );

  tdc_host_model host (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff)
  );

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // read and compare; a missing answer ends the run
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED %s expected answer seen none", what);
      conclude();
    end else begin
      chk(what, d, exp);
    end
  endtask : rdc

  // one sample set, then idle cycles so the detector settles
  task automatic tick(input logic signed [7:0] x, input logic signed [7:0] y, input logic signed [7:0] z);
    @(posedge core_clk);
    accel_x <= x;
    accel_y <= y;
    accel_z <= z;
    sample_tick <= 1'b1;
    @(posedge core_clk);
    sample_tick <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : tick

  task automatic hold(input int ax, input logic signed [7:0] v, input int n);
    repeat (n) tick(ax == 0 ? v : 8'sh00, ax == 1 ? v : 8'sh00, ax == 2 ? v : 8'sh00);
    tick(8'sh00, 8'sh00, 8'sh00);
  endtask : hold

  task automatic quiet(input int n);
    repeat (n) tick(8'sh00, 8'sh00, 8'sh00);
  endtask : quiet

  // long quiet lets every detector return to idle, then the source is emptied
  task automatic settle();
    quiet(14);
    host.rd(tdc_pkg::TDC_OFF_SRC, junk, jok);
  endtask : settle

  // first tap, optional tap inside latency, second tap in the window
  task automatic dbl(input logic [7:0] cfg, input bit inner, input logic [7:0] exp);
    host.wr(tdc_pkg::TDC_OFF_CFG, cfg);
    hold(2, 8'sh05, 1);
    if (inner) begin
      hold(2, 8'sh05, 1);
    end else begin
      quiet(2);
    end
    quiet(2);
    hold(2, 8'shfb, 1);
    quiet(2);
    rdc(tdc_pkg::TDC_OFF_SRC, exp, "double source");
    settle();
  endtask : dbl

  // main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    rst_b = 1'b0;
    sample_tick = 1'b0;
    accel_x = 8'sh00;
    accel_y = 8'sh00;
    accel_z = 8'sh00;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rdc(tdc_pkg::TDC_OFF_CFG, 8'h00, "config reset");
    rdc(tdc_pkg::TDC_OFF_SRC, 8'h00, "source reset");
    rdc(tdc_pkg::TDC_OFF_THX, 8'h00, "thr x reset");
    rdc(tdc_pkg::TDC_OFF_THY, 8'h00, "thr y reset");
    rdc(tdc_pkg::TDC_OFF_THZ, 8'h00, "thr z reset");
    rdc(8'h30, 8'h00, "unmapped");
    $display("test reset values done");
    host.wr(tdc_pkg::TDC_OFF_CFG, 8'hff);
    rdc(tdc_pkg::TDC_OFF_CFG, 8'hff, "config rw");
    host.wr(tdc_pkg::TDC_OFF_THX, 8'hff);
    rdc(tdc_pkg::TDC_OFF_THX, 8'h7f, "thr x top bit");
    host.wr(tdc_pkg::TDC_OFF_SRC, 8'hff);
    rdc(tdc_pkg::TDC_OFF_SRC, 8'h00, "source write");
    host.wr(tdc_pkg::TDC_OFF_THX, 8'h02);
    host.wr(tdc_pkg::TDC_OFF_THY, 8'h83);
    rdc(tdc_pkg::TDC_OFF_THY, 8'h03, "thr y");
    host.wr(tdc_pkg::TDC_OFF_THZ, 8'h02);
    rdc(tdc_pkg::TDC_OFF_THZ, 8'h02, "thr z");
    $display("test access done");
    for (int i = 0; i < 7; i++) begin
      host.wr(tdc_pkg::TDC_OFF_CFG, t_cfg[i]);
      hold(t_ax[i], t_val[i], t_len[i]);
      quiet(2);
      chk("irq raised", {7'h00, tap_irq_ff}, {7'h00, t_exp[i][7]});
      rdc(tdc_pkg::TDC_OFF_SRC, t_exp[i], "single source");
      chk("irq cleared", {7'h00, tap_irq_ff}, 8'h00);
      rdc(tdc_pkg::TDC_OFF_SRC, 8'h00, "source cleared");
      settle();
    end
    $display("test single taps done");
    host.wr(tdc_pkg::TDC_OFF_CFG, 8'h45);
    hold(0, 8'sh05, 1);
    hold(1, 8'shfc, 1);
    rdc(tdc_pkg::TDC_OFF_SRC, 8'h90, "latched source");
    settle();
    host.wr(tdc_pkg::TDC_OFF_CFG, 8'h05);
    hold(0, 8'sh05, 1);
    hold(1, 8'shfc, 1);
    rdc(tdc_pkg::TDC_OFF_SRC, 8'ha2, "unlatched source");
    settle();
    $display("test latch done");
    dbl(8'h60, 1'b0, 8'hcc);
    dbl(8'h60, 1'b1, 8'hcc);
    dbl(8'he0, 1'b1, 8'h00);
    dbl(8'he0, 1'b0, 8'hcc);
    $display("test double taps done");
    conclude();
  end
endmodule : tb

// ---- sim/tdc_host_model.sv ----
// host model: drives the register port of the tap detect block
// assumes a read answer registered on the edge that takes the read
`timescale 1ns/10ps
module tdc_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // one-cycle write; released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // one-cycle read, answer awaited under a bound
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (reg_rvalid_ff === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata_ff;
      end else begin
        @(posedge core_clk);
      end
    end
  endtask : rd
endmodule : tdc_host_model

// ---- verilog/tdc_axis_detect.sv ----
// one axis of the tap detector: threshold start, time limit, latency, second-tap window
// assumes sample_tick marks one new sample per output data period
`timescale 1ns/10ps
module tdc_axis_detect (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // sample stream
  input wire logic sample_tick,
  input wire logic signed [7:0] sample,
  // settings
  input wire logic [6:0] limit,
  input wire logic [7:0] time_limit,
  input wire logic [7:0] latency,
  input wire logic [7:0] window,
  input wire logic abort_on,
  // events
  output logic single_tap_ff,
  output logic double_tap_ff,
  output logic tap_sign_ff
);
  tdc_pkg::tdc_state_t state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt;
  logic nxt_sign, nxt_single, nxt_double;
  logic in_tap_ff, nxt_in_tap;
  logic no_window_ff, nxt_no_window;
  logic [7:0] mag;
  logic above;

  // magnitude in threshold steps; range is fixed regardless of full scale
  assign mag = sample[7] ? 8'(-sample) : 8'(sample); // RULE_17
  assign above = mag > {1'b0, limit}; // RULE_15

  // next-state logic, advanced only on sample ticks
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sign = tap_sign_ff;
    nxt_single = 1'b0;
    nxt_double = 1'b0;
    nxt_in_tap = in_tap_ff;
    nxt_no_window = no_window_ff;
    if (sample_tick) begin
      unique case (state_ff)
        tdc_pkg::TDC_IDLE: begin
          if (above) begin // RULE_15
            nxt_state = tdc_pkg::TDC_ABOVE;
            nxt_cnt = tdc_pkg::TDC_RST_CNT;
            nxt_sign = sample[7];
          end
        end
        tdc_pkg::TDC_ABOVE, tdc_pkg::TDC_ABOVE2: begin
          if (!above) begin // RULE_19
            nxt_single = (state_ff == tdc_pkg::TDC_ABOVE);
            nxt_double = (state_ff == tdc_pkg::TDC_ABOVE2);
            nxt_state = tdc_pkg::TDC_LATENCY;
            nxt_cnt = tdc_pkg::TDC_RST_CNT;
            nxt_in_tap = 1'b0;
            nxt_no_window = (state_ff == tdc_pkg::TDC_ABOVE2); // no third tap after a double
          end else if (cnt_ff >= time_limit) begin
            nxt_state = tdc_pkg::TDC_WAIT_LOW; // too long: not a tap
          end else begin
            nxt_cnt = cnt_ff + 8'h01;
          end
        end
        tdc_pkg::TDC_WAIT_LOW: begin
          if (!above) begin
            nxt_state = tdc_pkg::TDC_IDLE;
          end
        end
        tdc_pkg::TDC_LATENCY: begin
          // taps are ignored here; only the abort option watches them
          if (above) begin // RULE_18
            nxt_in_tap = 1'b1;
          end else if (in_tap_ff) begin
            nxt_in_tap = 1'b0;
            if (abort_on) begin
              nxt_no_window = 1'b1; // RULE_02
            end
          end
          if (cnt_ff >= latency) begin
            nxt_cnt = tdc_pkg::TDC_RST_CNT;
            nxt_in_tap = 1'b0;
            // with abort off the search goes on after a single tap, whatever happens in latency
            nxt_state = nxt_no_window ? tdc_pkg::TDC_IDLE : tdc_pkg::TDC_WINDOW; // RULE_01
          end else begin
            nxt_cnt = cnt_ff + 8'h01;
          end
        end
        tdc_pkg::TDC_WINDOW: begin
          if (above) begin
            nxt_state = tdc_pkg::TDC_ABOVE2;
            nxt_cnt = tdc_pkg::TDC_RST_CNT;
            nxt_sign = sample[7];
          end else if (cnt_ff >= window) begin
            nxt_state = tdc_pkg::TDC_IDLE;
          end else begin
            nxt_cnt = cnt_ff + 8'h01;
          end
        end
        default: begin
          nxt_state = tdc_pkg::TDC_IDLE;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= tdc_pkg::TDC_IDLE;
      cnt_ff <= tdc_pkg::TDC_RST_CNT;
      tap_sign_ff <= 1'b0;
      single_tap_ff <= 1'b0;
      double_tap_ff <= 1'b0;
      in_tap_ff <= 1'b0;
      no_window_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      tap_sign_ff <= nxt_sign;
      single_tap_ff <= nxt_single;
      double_tap_ff <= nxt_double;
      in_tap_ff <= nxt_in_tap;
      no_window_ff <= nxt_no_window;
    end
  end
endmodule : tdc_axis_detect

// ---- verilog/tdc_top.sv ----
// tap detect register set: config, source, per-axis thresholds, three axis detectors
// assumes a single-cycle register port behind the serial interface, samples synchronous to core_clk
`timescale 1ns/10ps
// What this block does
// RULE_01: abort bit clear: double-tap search continues despite a tap inside latency.
// RULE_02: abort bit set: tap starting and ending inside latency suspends double-tap search.
// RULE_03: latch bit set latches tap flags into source; clear disables latching.
// RULE_04: config bits 5,3,1 enable double-tap flags for Z, Y, X.
// RULE_05: config bits 4,2,0 enable single-tap flags for Z, Y, X.
// RULE_06: every config bit resets to zero.
// RULE_07: event reported only when its axis and its type are enabled.
// RULE_08: source bit 7 is one once any tap event was generated.
// RULE_09: source bits 6,5,4 flag Z, Y, X events; reset zero.
// RULE_10: source bit 3 is zero for single, one for double tap.
// RULE_11: source bits 2,1,0 give Z, Y, X polarity; one means negative.
// RULE_12: event active set with latch on freezes all other status bits.
// RULE_13: reading source clears it and drops the tap interrupt.
// RULE_14: separate 7-bit thresholds for X, Y, Z; top bit reads zero.
// RULE_15: detection starts when axis magnitude exceeds its threshold.
// RULE_16: thresholds reset to zero.
// RULE_17: threshold is unsigned, fixed step, independent of full scale.
// RULE_18: after a first tap all taps are ignored for the latency time.
// RULE_19: tap valid only if signal falls below threshold within time limit.
// RULE_20: writes to the source register are ignored.
module tdc_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  // samples, signed, one count per threshold step
  input wire logic sample_tick,
  input wire logic signed [7:0] accel_x,
  input wire logic signed [7:0] accel_y,
  input wire logic signed [7:0] accel_z,
  // timer settings held elsewhere, in sample ticks
  input wire logic [7:0] tap_time_limit,
  input wire logic [7:0] tap_latency_window,
  input wire logic [7:0] tap_second_window,
  // interrupt
  output logic tap_irq_ff
);
  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] src_ff, nxt_src;
  logic [6:0] thr_x_ff, nxt_thr_x;
  logic [6:0] thr_y_ff, nxt_thr_y;
  logic [6:0] thr_z_ff, nxt_thr_z;
  logic [7:0] nxt_rdata;
  logic nxt_rvalid, nxt_irq;
  logic [2:0] det_single, det_double, det_sign;
  logic [2:0] en_single, en_double, ev_single, ev_double, ev_axis;
  logic any_ev, frozen, rd_src, wr_cfg, wr_src;
  logic [7:0] ev_word;
  logic signed [7:0] accel [3];
  logic [6:0] thr [3];

  assign accel[0] = accel_x;
  assign accel[1] = accel_y;
  assign accel[2] = accel_z;
  assign thr[0] = thr_x_ff;
  assign thr[1] = thr_y_ff;
  assign thr[2] = thr_z_ff;

  // one detector per axis, index 0 = X, 1 = Y, 2 = Z
  for (genvar i = 0; i < 3; i++) begin : g_axis
    tdc_axis_detect u_det (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .sample_tick(sample_tick),
      .sample(accel[i]),
      .limit(thr[i]),
      .time_limit(tap_time_limit),
      .latency(tap_latency_window),
      .window(tap_second_window),
      .abort_on(cfg_ff[tdc_pkg::TDC_CFG_ABORT]),
      .single_tap_ff(det_single[i]),
      .double_tap_ff(det_double[i]),
      .tap_sign_ff(det_sign[i])
    );
  end

  // per-axis enables out of the config register
  assign en_single = {cfg_ff[tdc_pkg::TDC_CFG_ZS], cfg_ff[tdc_pkg::TDC_CFG_YS], cfg_ff[tdc_pkg::TDC_CFG_XS]}; // RULE_05
  assign en_double = {cfg_ff[tdc_pkg::TDC_CFG_ZD], cfg_ff[tdc_pkg::TDC_CFG_YD], cfg_ff[tdc_pkg::TDC_CFG_XD]}; // RULE_04

  // events pass only when axis and type are both enabled
  assign ev_single = det_single & en_single; // RULE_07
  assign ev_double = det_double & en_double; // RULE_07
  assign ev_axis = ev_single | ev_double;
  assign any_ev = |ev_axis;

  // status word for a fresh event; polarity only for axes that fired
  assign ev_word = {1'b1, ev_axis, |ev_double, det_sign & ev_axis}; // RULE_08 RULE_09 RULE_10 RULE_11

  // access decode
  assign rd_src = reg_rd && (reg_addr == tdc_pkg::TDC_OFF_SRC);
  assign wr_cfg = reg_wr && (reg_addr == tdc_pkg::TDC_OFF_CFG);
  assign wr_src = reg_wr && (reg_addr == tdc_pkg::TDC_OFF_SRC);
  assign frozen = cfg_ff[tdc_pkg::TDC_CFG_LATCH] && src_ff[tdc_pkg::TDC_SRC_EA]; // RULE_03 RULE_12

  // writable registers; the source register has no write path at all
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_thr_x = thr_x_ff;
    nxt_thr_y = thr_y_ff;
    nxt_thr_z = thr_z_ff;
    if (wr_cfg) begin
      nxt_cfg = reg_wdata;
    end
    if (reg_wr && (reg_addr == tdc_pkg::TDC_OFF_THX)) begin
      nxt_thr_x = reg_wdata[6:0]; // RULE_14
    end
    if (reg_wr && (reg_addr == tdc_pkg::TDC_OFF_THY)) begin
      nxt_thr_y = reg_wdata[6:0]; // RULE_14
    end
    if (reg_wr && (reg_addr == tdc_pkg::TDC_OFF_THZ)) begin
      nxt_thr_z = reg_wdata[6:0]; // RULE_14
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= tdc_pkg::TDC_RST_CFG; // RULE_06
      thr_x_ff <= tdc_pkg::TDC_RST_THR; // RULE_16
      thr_y_ff <= tdc_pkg::TDC_RST_THR;
      thr_z_ff <= tdc_pkg::TDC_RST_THR;
    end else begin
      cfg_ff <= nxt_cfg;
      thr_x_ff <= nxt_thr_x;
      thr_y_ff <= nxt_thr_y;
      thr_z_ff <= nxt_thr_z;
    end
  end

  // source register: read clears, a coincident event wins over the clear
  always_comb begin
    nxt_src = src_ff; // RULE_20
    if (rd_src) begin
      nxt_src = tdc_pkg::TDC_RST_SRC; // RULE_13
    end
    // when latched and active, new events are dropped unless they arrive in the same cycle as a source read
    if (any_ev && (!frozen || rd_src)) begin
      nxt_src = ev_word; // RULE_12
    end
    nxt_irq = nxt_src[tdc_pkg::TDC_SRC_EA]; // RULE_08 RULE_13
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_ff <= tdc_pkg::TDC_RST_SRC;
      tap_irq_ff <= 1'b0;
    end else begin
      src_ff <= nxt_src;
      tap_irq_ff <= nxt_irq;
    end
  end

  // read mux; the value read is the one before any clear
  always_comb begin
    nxt_rvalid = reg_rd;
    nxt_rdata = reg_rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        tdc_pkg::TDC_OFF_CFG: nxt_rdata = cfg_ff;
        tdc_pkg::TDC_OFF_SRC: nxt_rdata = src_ff;
        tdc_pkg::TDC_OFF_THX: nxt_rdata = {1'b0, thr_x_ff}; // RULE_14
        tdc_pkg::TDC_OFF_THY: nxt_rdata = {1'b0, thr_y_ff}; // RULE_14
        tdc_pkg::TDC_OFF_THZ: nxt_rdata = {1'b0, thr_z_ff}; // RULE_14
        default: nxt_rdata = tdc_pkg::TDC_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= tdc_pkg::TDC_RD_UNMAPPED;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rdata_ff <= nxt_rdata;
      reg_rvalid_ff <= nxt_rvalid;
    end
  end

  // checks on the register set
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_src_freeze: assert property ( // RULE_12
    frozen && !rd_src |=> $stable(src_ff))
    else $error("source changed while latched");

  chk_read_clear: assert property ( // RULE_13
    rd_src && !any_ev |=> (src_ff == 8'h00) && !tap_irq_ff)
    else $error("source read did not clear");

  chk_src_nowrite: assert property ( // RULE_20
    wr_src && !any_ev |=> $stable(src_ff))
    else $error("write altered source");

  chk_event_sets: assert property ( // RULE_08
    any_ev && !frozen |=> src_ff[7] && tap_irq_ff)
    else $error("event did not raise active flag");

  chk_ea_cause: assert property ( // RULE_07
    $rose(src_ff[7]) |-> $past(any_ev))
    else $error("active flag without enabled event");

  chk_dbl_type: assert property ( // RULE_10
    any_ev && !frozen |=> src_ff[3] == ($past(ev_double) != 3'h0))
    else $error("double flag mismatch");

  chk_pol_capture: assert property ( // RULE_11
    ev_axis[0] && !frozen |=> src_ff[4] && (src_ff[0] == $past(det_sign[0])))
    else $error("x polarity not captured");

  chk_thr_top: assert property ( // RULE_14
    reg_rd && (reg_addr == tdc_pkg::TDC_OFF_THX) |=> reg_rvalid_ff && !reg_rdata_ff[7] &&
      (reg_rdata_ff[6:0] == thr_x_ff))
    else $error("x threshold readback wrong");

  // written bits 5, 3, 1 must land as the z, y, x double enables
  chk_cfg_write: assert property ( // RULE_04
    wr_cfg |=> (cfg_ff == $past(reg_wdata)) &&
      ({2'h0, en_double[2], 1'b0, en_double[1], 1'b0, en_double[0], 1'b0} == ($past(reg_wdata) & 8'h2a)))
    else $error("config write lost");

  // source word invariants: active flag, axis flags and polarity agree
  chk_ea_flags: assert property ( // RULE_08
    src_ff[tdc_pkg::TDC_SRC_EA] == (|src_ff[6:4]))
    else $error("active flag and axis flags disagree");

  chk_idle_zero: assert property ( // RULE_09
    !src_ff[tdc_pkg::TDC_SRC_EA] |-> (src_ff == tdc_pkg::TDC_RST_SRC))
    else $error("status bits set without active flag");

  chk_pol_axis: assert property ( // RULE_11
    (src_ff[2:0] & ~src_ff[6:4]) == 3'h0)
    else $error("polarity set for an axis that did not fire");

  chk_ea_only_read: assert property ( // RULE_13
    $fell(src_ff[tdc_pkg::TDC_SRC_EA]) |-> $past(rd_src))
    else $error("active flag dropped without a read");

  chk_src_read_value: assert property ( // RULE_13
    rd_src |=> reg_rvalid_ff && (reg_rdata_ff == $past(src_ff)))
    else $error("source read returned wrong value");

  chk_freeze_irq: assert property ( // RULE_12
    frozen && !rd_src |=> tap_irq_ff)
    else $error("interrupt dropped while latched");

  chk_latch_off: assert property ( // RULE_03
    any_ev && !cfg_ff[tdc_pkg::TDC_CFG_LATCH] |=> (src_ff == $past(ev_word)))
    else $error("unlatched event not taken");

  // event gating and capture per axis
  chk_x_gate: assert property ( // RULE_07
    $rose(src_ff[tdc_pkg::TDC_SRC_AX_LO]) |->
      (($past(det_single[0]) && $past(cfg_ff[tdc_pkg::TDC_CFG_XS])) ||
      ($past(det_double[0]) && $past(cfg_ff[tdc_pkg::TDC_CFG_XD]))))
    else $error("x flag without enabled x event");

  chk_dbl_cause: assert property ( // RULE_04
    $rose(src_ff[tdc_pkg::TDC_SRC_DBL]) |-> ($past(ev_double) != 3'h0))
    else $error("double flag without enabled double event");

  chk_pol_y: assert property ( // RULE_11
    ev_axis[1] && !frozen |=> src_ff[5] && (src_ff[1] == $past(det_sign[1])))
    else $error("y polarity not captured");

  chk_pol_z: assert property ( // RULE_11
    ev_axis[2] && !frozen |=> src_ff[6] && (src_ff[2] == $past(det_sign[2])))
    else $error("z polarity not captured");

  // register access; a write never produces a read answer
  chk_rvalid_idle: assert property (
    !reg_rd |=> !reg_rvalid_ff)
    else $error("read answer without a read");

  chk_cfg_read: assert property ( // RULE_05
    reg_rd && (reg_addr == tdc_pkg::TDC_OFF_CFG) |=> reg_rvalid_ff && (reg_rdata_ff == $past(cfg_ff)))
    else $error("config readback wrong");

  chk_thr_z_read: assert property ( // RULE_14
    reg_rd && (reg_addr == tdc_pkg::TDC_OFF_THZ) |=> reg_rvalid_ff && (reg_rdata_ff == {1'b0, thr_z_ff}))
    else $error("z threshold readback wrong");

  chk_thr_x_write: assert property ( // RULE_14
    reg_wr && (reg_addr == tdc_pkg::TDC_OFF_THX) |=> ({1'b0, thr_x_ff} == ($past(reg_wdata) & 8'h7f)))
    else $error("x threshold write lost");

  chk_thr_y_write: assert property ( // RULE_14
    reg_wr && (reg_addr == tdc_pkg::TDC_OFF_THY) |=> ({1'b0, thr_y_ff} == ($past(reg_wdata) & 8'h7f)))
    else $error("y threshold write lost");

  chk_thr_z_write: assert property ( // RULE_14
    reg_wr && (reg_addr == tdc_pkg::TDC_OFF_THZ) |=> ({1'b0, thr_z_ff} == ($past(reg_wdata) & 8'h7f)))
    else $error("z threshold write lost");

  cov_double_event: cover property (any_ev && (|ev_double));
  cov_latched_hold: cover property (frozen && any_ev ##1 frozen);
  cov_read_vs_event: cover property (rd_src && any_ev);
  cov_single_event: cover property (any_ev && (|ev_single));
  cov_unlatched_over: cover property (any_ev && !cfg_ff[tdc_pkg::TDC_CFG_LATCH] && src_ff[tdc_pkg::TDC_SRC_EA]);
endmodule : tdc_top
